// *** src/sarseq_map.vh ***
/*
 * shared constants of the conversion sequencer: bit count, phase codes,
 * timing counts and output code limits.
 * assumes a 200 MHz clock; included by bare name.
 */
`ifndef SARSEQ_MAP_VH
`define SARSEQ_MAP_VH

`define SARSEQ_NBITS 16
// clock rate and conversion timing
`define SARSEQ_CLK_MHZ 200
`define SARSEQ_SPS_MAX 600000
// one conversion period at the top rate, in ns (rounded down)
`define SARSEQ_PERIOD_NS 1666
`define SARSEQ_PERIOD_CYC ((`SARSEQ_PERIOD_NS * `SARSEQ_CLK_MHZ) / 1000)
// internal conversion clock divider: one bit step every N cycles
`define SARSEQ_BIT_DIV 8
// settle cycles for the switch steps
`define SARSEQ_SW_SETTLE 2
// phase codes
`define SARSEQ_ST_ACQ 3'h0
`define SARSEQ_ST_OPEN 3'h1
`define SARSEQ_ST_HOLD 3'h2
`define SARSEQ_ST_BITS 3'h3
`define SARSEQ_ST_DONE 3'h4
// output code limits
`define SARSEQ_CODE_ZERO 16'h0000
`define SARSEQ_CODE_FULL 16'hffff
`define SARSEQ_CODE_MID 16'h8000

`endif

// *** src/sarseq_sync.v ***
/*
 * three-stage synchroniser with agreement filter for one pin input.
 * assumes the pin is asynchronous to i_clk.
 */
module sarseq_sync (
	input wire i_clk,
	input wire i_rst_n,
	input wire i_pin,
	output reg o_level
);

reg stage1;
reg stage2;
reg stage3;

always @(posedge i_clk or negedge i_rst_n) begin
	if (!i_rst_n) begin
		stage1 <= 1'b0;
		stage2 <= 1'b0;
		stage3 <= 1'b0;
		o_level <= 1'b0;
	end else begin
		stage1 <= i_pin;
		stage2 <= stage1;
		stage3 <= stage2;
		// change counts once stages two and three agree
		if (stage2 == stage3) begin
			o_level <= stage3;
		end
	end
end

endmodule // sarseq_sync

// *** src/sarseq_core.v ***
/*
 * successive-approximation conversion sequencer: start edge detection,
 * switch sequencing, 16-bit binary search, result and busy indication.
 * assumes a comparator output (high: sampled input above dac level),
 * an asynchronous start pin and a 200 MHz clock.
 */
`include "sarseq_map.vh"

// Contract
// RQ1: start rising edge ends acquisition, begins conversion
// RQ2: open ground switches before grounding arrays
// RQ3: binary search, sixteen bits, msb first
// RQ4: back to acquisition, code and busy end
// RQ5: bits timed by internal divider, not readout clock
// RQ6: up to 600 kSPS, power down between
// RQ7: result belongs to own start edge
// RQ8: straight binary sixteen-bit output code
// RQ9: overrange gives all ones, underrange zeros
// RQ10: ignore start edges during conversion
module sarseq_core #(
	parameter NBITS = `SARSEQ_NBITS,
	parameter BIT_DIV = `SARSEQ_BIT_DIV
) (
	input wire i_clk,
	input wire i_rst_n,
	input wire i_conversion_start,
	input wire i_comparator,
	output reg o_positive_array_ground_switch,
	output reg o_negative_array_ground_switch,
	output reg o_array_to_ground,
	output reg [NBITS-1:0] o_dac_bits,
	output reg o_powered,
	output reg o_busy,
	output reg o_done,
	output reg [NBITS-1:0] o_code
);

// ==========================================================
// phase codes and local limits
localparam [2:0] ST_ACQ = `SARSEQ_ST_ACQ;
localparam [2:0] ST_OPEN = `SARSEQ_ST_OPEN;
localparam [2:0] ST_HOLD = `SARSEQ_ST_HOLD;
localparam [2:0] ST_BITS = `SARSEQ_ST_BITS;
localparam [2:0] ST_DONE = `SARSEQ_ST_DONE;
localparam [3:0] SETTLE_LAST = `SARSEQ_SW_SETTLE - 1;
localparam [4:0] MSB_IDX = NBITS - 1;
localparam [7:0] DIV_LAST = BIT_DIV - 1;

// ==========================================================
// start input
wire start_level;
reg start_prev;

sarseq_sync u_start_sync (
	.i_clk(i_clk),
	.i_rst_n(i_rst_n),
	.i_pin(i_conversion_start),
	.o_level(start_level)
);

always @(posedge i_clk or negedge i_rst_n) begin
	if (!i_rst_n) begin
		start_prev <= 1'b0;
	end else begin
		start_prev <= start_level;
	end
end

wire start_edge = start_level & ~start_prev;

// ==========================================================
// conversion clock divider
reg [7:0] div_cnt;
reg bit_tick;

always @(posedge i_clk or negedge i_rst_n) begin
	if (!i_rst_n) begin
		div_cnt <= 8'h00;
		bit_tick <= 1'b0;
	end else if (!o_powered) begin
		div_cnt <= 8'h00;
		bit_tick <= 1'b0;
	end else if (div_cnt == DIV_LAST) begin
		div_cnt <= 8'h00;
		bit_tick <= 1'b1; // RQ5
	end else begin
		div_cnt <= div_cnt + 8'h01;
		bit_tick <= 1'b0;
	end
end

// ==========================================================
// sequencer
reg [2:0] state;
reg [2:0] next_state;
reg [3:0] settle;
reg [4:0] bit_idx;
reg [NBITS-1:0] trial;
wire [NBITS-1:0] next_trial;

always @* begin
	next_state = state;
	case (state)
	ST_ACQ: begin
		// edges that arrive while busy never reach this branch
		if (start_edge) begin
			next_state = ST_OPEN; // RQ1 RQ10
		end
	end
	ST_OPEN: begin
		if (settle == SETTLE_LAST) begin
			next_state = ST_HOLD; // RQ2
		end
	end
	ST_HOLD: begin
		if (settle == SETTLE_LAST) begin
			next_state = ST_BITS;
		end
	end
	ST_BITS: begin
		if (bit_tick && bit_idx == 5'h00) begin
			next_state = ST_DONE;
		end
	end
	ST_DONE: begin
		next_state = ST_ACQ; // RQ4
	end
	default: begin
		next_state = ST_ACQ;
	end
	endcase
end

// ==========================================================
// per-bit trial code: msb first, one decision per bit tick
wire load_msb = (state == ST_HOLD) && (next_state == ST_BITS);
wire bit_step = (state == ST_BITS) && bit_tick;

genvar gi;
generate
	for (gi = 0; gi < NBITS; gi = gi + 1) begin : g_trial
		if (gi == NBITS - 1) begin : g_top
			// msb: first trial bit; comparator high keeps it, rails saturate
			assign next_trial[gi] = load_msb ? 1'b1 :
				(bit_step && bit_idx == gi) ? i_comparator : trial[gi]; // RQ3 RQ9
		end else begin : g_low
			// lower bit: becomes the trial bit once the bit above is decided
			assign next_trial[gi] = load_msb ? 1'b0 :
				(bit_step && bit_idx == gi) ? i_comparator :
				(bit_step && bit_idx == gi + 1) ? 1'b1 : trial[gi]; // RQ3 RQ9
		end
	end
endgenerate

// ==========================================================
// phase register, settle counter and bit index
always @(posedge i_clk or negedge i_rst_n) begin
	if (!i_rst_n) begin
		state <= ST_ACQ;
		settle <= 4'h0;
		bit_idx <= 5'h00;
		trial <= `SARSEQ_CODE_ZERO;
	end else begin
		state <= next_state;
		trial <= next_trial;
		if (next_state != state) begin
			settle <= 4'h0;
		end else begin
			settle <= settle + 4'h1;
		end
		if (load_msb) begin
			bit_idx <= MSB_IDX; // RQ3
		end else if (bit_step && bit_idx != 5'h00) begin
			bit_idx <= bit_idx - 5'h01;
		end
	end
end

// ==========================================================
// switch, power and result outputs
always @(posedge i_clk or negedge i_rst_n) begin
	if (!i_rst_n) begin
		o_positive_array_ground_switch <= 1'b1;
		o_negative_array_ground_switch <= 1'b1;
		o_array_to_ground <= 1'b0;
		o_dac_bits <= `SARSEQ_CODE_ZERO;
		o_powered <= 1'b0;
		o_busy <= 1'b0;
		o_done <= 1'b0;
		o_code <= `SARSEQ_CODE_ZERO;
	end else begin
		o_done <= 1'b0;
		case (next_state)
		ST_OPEN: begin
			// ground switches open while arrays still track
			o_positive_array_ground_switch <= 1'b0; // RQ2
			o_negative_array_ground_switch <= 1'b0;
			o_powered <= 1'b1; // RQ6
			o_busy <= 1'b1; // RQ10
		end
		ST_HOLD: begin
			o_array_to_ground <= 1'b1; // RQ2
		end
		ST_BITS: begin
			o_dac_bits <= next_trial;
		end
		ST_DONE: begin
			// the lsb decision lands on this same edge, so take the next value
			o_code <= next_trial; // RQ7 RQ8
			o_done <= 1'b1; // RQ4
		end
		default: begin
			// acquisition: arrays back on inputs, converter powered down
			o_positive_array_ground_switch <= 1'b1;
			o_negative_array_ground_switch <= 1'b1;
			o_array_to_ground <= 1'b0;
			o_dac_bits <= `SARSEQ_CODE_ZERO;
			o_powered <= 1'b0; // RQ6
			o_busy <= 1'b0; // RQ4
		end
		endcase
	end
end

endmodule // sarseq_core

// *** verification/sarseq_chk.sv ***
/* port assertions of the conversion sequencer.
   assumes one clock, reset async low. */
module sarseq_chk #(parameter NBITS = 16) (
	input wire i_clk,
	input wire i_rst_n,
	input wire o_positive_array_ground_switch,
	input wire o_negative_array_ground_switch,
	input wire o_array_to_ground,
	input wire [NBITS-1:0] o_dac_bits,
	input wire o_powered,
	input wire o_busy,
	input wire o_done,
	input wire [NBITS-1:0] o_code
);
timeunit 1ns;
timeprecision 100ps;
// ====================
// checks
default clocking @(posedge i_clk);
endclocking
default disable iff (!i_rst_n);
AST_SW_OPEN: assert property ($rose(o_busy) |->
	!o_positive_array_ground_switch && !o_negative_array_ground_switch) else $error("sw");
AST_GND: assert property ($rose(o_busy) |-> !o_array_to_ground ##2 o_array_to_ground)
	else $error("gnd");
AST_MSB: assert property ($rose(o_array_to_ground) |-> ##2 o_dac_bits == 16'h8000)
	else $error("msb");
AST_LEN: assert property ($rose(o_busy) |-> ##[128:140] o_done)
	else $error("len");
AST_END: assert property (o_done |=> !o_busy && o_positive_array_ground_switch)
	else $error("end");
AST_PWR: assert property (o_powered == o_busy)
	else $error("pwr");
AST_HOLD: assert property (!o_done |-> $stable(o_code))
	else $error("hold");
AST_IDLE: assert property (!o_busy |-> o_dac_bits == 16'h0000)
	else $error("idle");
endmodule // sarseq_chk
bind sarseq_core sarseq_chk #(.NBITS(NBITS)) u_chk (
	.i_clk(i_clk),
	.i_rst_n(i_rst_n),
	.o_positive_array_ground_switch(o_positive_array_ground_switch),
	.o_negative_array_ground_switch(o_negative_array_ground_switch),
	.o_array_to_ground(o_array_to_ground),
	.o_dac_bits(o_dac_bits),
	.o_powered(o_powered),
	.o_busy(o_busy),
	.o_done(o_done),
	.o_code(o_code)
);

// *** verification/sarseq_cmp_model.sv ***
/* comparator stand-in at the far side.
   assumes a 17-bit level; above 16'hffff is overrange. */
module sarseq_cmp_model (
	input wire [16:0] i_level,
	input wire [15:0] i_dac_bits,
	output wire o_comparator
);
timeunit 1ns;
timeprecision 100ps;
// ====================
// level at or above the trial code keeps the bit
assign o_comparator = i_level >= {1'b0, i_dac_bits};
endmodule // sarseq_cmp_model

// *** verification/test_sar_conversion_sequencer.sv ***
/* self-checking bench of the conversion sequencer.
   assumes the design and its checker are compiled. */
module test_sar_conversion_sequencer;
timeunit 1ns;
timeprecision 100ps;
logic i_clk = 0, i_rst_n = 0, i_conversion_start = 0;
logic [16:0] level = 0;
wire i_comparator, o_positive_array_ground_switch, o_negative_array_ground_switch;
wire o_array_to_ground, o_powered, o_busy, o_done;
wire [15:0] o_dac_bits, o_code;
int error_cnt = 0, comparisons = 0, cyc = 0;
sarseq_core dut (
	.i_clk(i_clk),
	.i_rst_n(i_rst_n),
	.i_conversion_start(i_conversion_start),
	.i_comparator(i_comparator),
	.o_positive_array_ground_switch(o_positive_array_ground_switch),
	.o_negative_array_ground_switch(o_negative_array_ground_switch),
	.o_array_to_ground(o_array_to_ground),
	.o_dac_bits(o_dac_bits),
	.o_powered(o_powered),
	.o_busy(o_busy),
	.o_done(o_done),
	.o_code(o_code)
);
sarseq_cmp_model cmp (.i_level(level), .i_dac_bits(o_dac_bits), .o_comparator(i_comparator));
// ====================
// clock, timeout, tasks
initial forever #2.5 i_clk = ~i_clk;
always @(posedge i_clk) begin
	if (++cyc == 4000) begin
		error_cnt++;
		report_and_stop();
	end
end
task check(input logic [15:0] got, input logic [15:0] exp);
	comparisons++;
	if (got !== exp) begin
		error_cnt++;
		$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
	end
endtask
task conv(input logic [16:0] lv, input logic [15:0] exp);
	int n;
	n = 0;
	level = lv;
	repeat (4) @(posedge i_clk);
	#1 i_conversion_start = 1;
	while (o_done !== 1'b1 && n < 300) begin
		@(posedge i_clk);
		#1 n++;
	end
	// pin sync, two switch steps, sixteen ticks of eight cycles; a restart edge mid-conversion adds no cycles
	check(16'(n), 16'h0086);
	check(o_code, exp);
	i_conversion_start = 0;
endtask
task t_codes;
	logic [16:0] lv [6] = '{17'h00000, 17'h07fff, 17'h08000, 17'h08001, 17'h0ffff, 17'h10000};
	for (int i = 0; i < 6; i++) begin
		conv(lv[i], lv[i] > 17'h0ffff ? 16'hffff : lv[i][15:0]);
	end
	$display("codes test ended");
endtask
task t_retrig;
	fork
		conv(17'h0a5c3, 16'ha5c3);
		begin
			repeat (40) @(posedge i_clk);
			#1 i_conversion_start = 0;
			repeat (6) @(posedge i_clk);
			#1 i_conversion_start = 1;
		end
	join
	repeat (20) @(posedge i_clk);
	check({15'h0000, o_busy}, 16'h0000);
	$display("retrigger test ended");
endtask
task t_reset;
	check({10'h000, o_positive_array_ground_switch, o_negative_array_ground_switch,
		o_array_to_ground, o_powered, o_busy, o_done}, 16'h0030);
	check(o_dac_bits, 16'h0000);
	check(o_code, 16'h0000);
	$display("reset test ended");
endtask
task report_and_stop;
	$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
	if (error_cnt == 0 && comparisons > 0) begin
		$display("ALL TESTS PASSED");
	end else begin
		$display("TESTS FAILED");
	end
	$finish;
endtask
initial begin
	repeat (5) @(posedge i_clk);
	#1 i_rst_n = 1;
	t_reset();
	t_codes();
	t_retrig();
	report_and_stop();
end
endmodule // test_sar_conversion_sequencer
